// ===== shared/mpfh_pkg.sv
// Purpose: Shared constants and types of the motion profile and fast homing block
// Assumes: 25 MHz control clock, 32-bit register words at byte addresses
// Notes: Speeds in Hz, rates in Hz/s, ramp settings as integers of 0.001 of the selected unit
`default_nettype none
package mpfh_pkg;
	// ==========
	// Types
	typedef logic [7:0] mpfh_addr_type;
	typedef logic [31:0] mpfh_word_type;
	// Acceleration unit codes
	typedef enum logic [1:0] {UNIT_KHZ_PER_S, UNIT_SECONDS, UNIT_MS_PER_KHZ} mpfh_unit_type;

	// ==========
	// Clock and fixed-point scaling
	localparam int unsigned CLK_PERIOD_NS = 32'h28;
	localparam int unsigned NS_PER_S = 32'h3B9ACA00;
	localparam int unsigned CLK_HZ = NS_PER_S / CLK_PERIOD_NS;
	localparam int VEL_W = 48; // Speed in units of 1/CLK_HZ Hz
	localparam int PH_W = 51; // Step phase accumulator
	localparam logic [VEL_W-1:0] CLK_HZ_V = VEL_W'(CLK_HZ);
	localparam logic [PH_W-1:0] STEP_THRESH = PH_W'(CLK_HZ_V) * PH_W'(CLK_HZ_V);
	localparam mpfh_word_type MS_PER_S = 32'h3E8; // Setting weight 0.001
	localparam mpfh_word_type RATE_MIN = 32'h1; // 1 Hz/s
	localparam mpfh_word_type RATE_MAX = 32'h3B9ACA00; // 1 GHz/s
	localparam mpfh_word_type RATE_NUM_INV = 32'h3B9ACA00; // 1e9 for ms/kHz inversion

	// ==========
	// Register byte addresses
	localparam mpfh_addr_type ADDR_ACCEL_UNIT = 8'h00;
	localparam mpfh_addr_type ADDR_SD_START_SPEED = 8'h04;
	localparam mpfh_addr_type ADDR_JOG_START_SPEED = 8'h08;
	localparam mpfh_addr_type ADDR_ZH_START_SPEED = 8'h0C;
	localparam mpfh_addr_type ADDR_HOME_START_SPEED = 8'h10;
	localparam mpfh_addr_type ADDR_FILTER_TIME = 8'h14;
	localparam mpfh_addr_type ADDR_OP_CURRENT = 8'h18;
	localparam mpfh_addr_type ADDR_ZH_SPEED = 8'h1C;
	localparam mpfh_addr_type ADDR_ZH_ACCEL = 8'h20;
	localparam mpfh_addr_type ADDR_HOME_POSITION = 8'h24;
	localparam mpfh_addr_type ADDR_CMD_TARGET = 8'h28;
	localparam mpfh_addr_type ADDR_CMD_SPEED = 8'h2C;
	localparam mpfh_addr_type ADDR_CONTROL = 8'h30;
	localparam mpfh_addr_type ADDR_STATUS = 8'h34;
	localparam mpfh_addr_type ADDR_POSITION = 8'h38;
	localparam mpfh_addr_type ADDR_RATE = 8'h3C;

	// ==========
	// Field positions
	localparam int CTL_FORGET_HOME = 0;
	localparam int CTL_CLEAR_ERR = 1;
	localparam int STS_START_ERR = 0;
	localparam int STS_HOME_VALID = 1;
	localparam int STS_MOVE = 2;
	localparam int STS_HOMING_DONE = 3;
	localparam int STS_READY = 4;

	// ==========
	// Limits and reset values
	localparam mpfh_word_type SPEED_MAX = 32'h3D0900;
	localparam mpfh_word_type START_SPEED_RST = 32'h1F4;
	localparam mpfh_word_type FILTER_MIN = 32'h1;
	localparam mpfh_word_type FILTER_MAX = 32'hC8;
	localparam mpfh_word_type FILTER_RST = 32'h1;
	localparam mpfh_word_type CURRENT_MAX = 32'h3E8;
	localparam mpfh_word_type CURRENT_RST = 32'h3E8;
	localparam mpfh_word_type ZH_SPEED_RST = 32'h1388;
	localparam mpfh_word_type ACCEL_MAX = 32'h3B9ACA00;
	localparam mpfh_word_type ACCEL_RST = 32'hF4240;

	// Saturate a written value into its legal range
	function automatic mpfh_word_type mpfh_clamp(mpfh_word_type v, mpfh_word_type lo, mpfh_word_type hi);
		mpfh_word_type r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// ===== hw/mpfh_sync.sv
// Purpose: Two-flop synchroniser for the discrete control pins
// Assumes: Each bit is an independent level
// Notes: Multi-bit groups are not coherent; only use for unrelated levels
`default_nettype none
module mpfh_sync #(
	parameter int W = 4
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	// ==========
	// Synchroniser stages
	logic [W-1:0] meta_q; // First stage, read only by the second

	// Both stages clear on reset, so a pin held high across reset rises at the output after release
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ===== hw/mpfh_div.sv
// Purpose: Sequential unsigned restoring divider for the ramp rate
// Assumes: Divisor is never zero; start is a one-cycle pulse
// Notes: W cycles from start to done; a new start restarts it
`default_nettype none
module mpfh_div #(
	parameter int W = 32
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [W-1:0] dividend,
	input wire logic [W-1:0] divisor,
	output logic done,
	output logic [W-1:0] quotient
);
	// ==========
	// State
	localparam int CW = $clog2(W + 1);
	logic [W-1:0] rem_q; // Partial remainder
	logic [W-1:0] den_q; // Latched divisor
	logic [CW-1:0] cnt_q; // Bits still to produce
	logic busy_q; // Iterating
	logic [W:0] trial; // Shifted remainder minus divisor

	assign trial = {rem_q, quotient[W-1]} - {1'b0, den_q};

	// One quotient bit per cycle, dividend shifts out as quotient shifts in
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rem_q <= '0;
			den_q <= '0;
			quotient <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			done <= 1'b0;
		end else if (start) begin
			rem_q <= '0;
			den_q <= divisor;
			quotient <= dividend;
			cnt_q <= CW'(W);
			busy_q <= 1'b1;
			done <= 1'b0;
		end else if (busy_q) begin
			// Negative trial means the divisor does not fit
			if (!trial[W]) begin
				rem_q <= trial[W-1:0];
				quotient <= {quotient[W-2:0], 1'b1};
			end else begin
				rem_q <= {rem_q[W-2:0], quotient[W-1]};
				quotient <= {quotient[W-2:0], 1'b0};
			end
			cnt_q <= cnt_q - CW'(1);
			if (cnt_q == CW'(1)) begin
				busy_q <= 1'b0;
				done <= 1'b1;
			end
		end else begin
			done <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== hw/mpfh_top.sv
// Purpose: Motion profile settings, trapezoid generator and fast homing handshake
// Assumes: Home coordinate loaded by software; pins asynchronous to sys_clk
// Notes: Step output is one pulse per step, at most one per clock
//
// Contract
// R1: Unit code 0 kHz/s, 1 s, 2 ms/kHz
// R2: Effective ramp rate kept within 1 Hz/s..1 GHz/s
// R3: Operating below starting speed runs without ramp
// R4: Stored and jog starting speeds 0..4M, default 500
// R5: Sensor homing starting speed 1..4M, default 500
// R6: Request rising edge moves to stored home
// R7: Stop input halts a running homing move
// R8: No home set: flag start error, no motion
// R9: Origin preset asserted refuses fast homing
// R10: Filter time 1..200 ms, default 1
// R11: Current 0..1000 default 1000; speed 1..4M, 5000
// R12: Homing ramp setting 1..1e9, default 1e6
// R13: Host requests only while ready is high
// R14: Accept drops ready outputs, raises move
// R15: Host releases request after ready drops
// R16: Arrival raises done and ready outputs, drops move
// R17: Start drops done, in-position, ready; raises move
// R18: Ramp start to operating speed and back down
// R19: Start error sticky; stop leaves move low
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`default_nettype none
module mpfh_top (
	input wire logic sys_clk,
	input wire logic reset,
	input wire mpfh_pkg::mpfh_addr_type reg_addr,
	input wire mpfh_pkg::mpfh_word_type reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output mpfh_pkg::mpfh_word_type reg_rdata,
	input wire logic fast_homing_request,
	input wire logic start_request,
	input wire logic stop_request,
	input wire logic electrical_origin_preset,
	output logic ready,
	output logic in_position,
	output logic pulse_input_ready,
	output logic direct_command_ready,
	output logic move,
	output logic homing_done,
	output logic step_pulse,
	output logic step_direction,
	output logic [9:0] operating_current,
	output logic [7:0] filter_time_ms
);
	import mpfh_pkg::*;

	// ==========
	// Declarations
	typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_RUN, ST_HOMED} mpfh_state_type;
	mpfh_state_type state_q; // Motion sequencer
	logic [3:0] pins_raw, pins_s, pins_prev_q; // Pin levels, synced and delayed
	logic home_req_s, start_s, stop_s, preset_s; // Synced pin levels
	logic home_rise, start_rise; // Request edges
	logic accept_home, home_error; // Request outcome
	mpfh_unit_type unit_q; // Acceleration unit selection
	mpfh_word_type sd_vs_q, jog_vs_q, zh_vs_q, home_vs_q; // Starting speeds
	mpfh_word_type filter_q, current_q, zh_vop_q, zh_acc_q; // Homing settings
	mpfh_word_type home_pos_q, cmd_target_q, cmd_vop_q; // Targets and speeds
	logic home_valid_q, start_err_q; // Home known, sticky start error
	logic homing_q, rect_q, div_start_q; // Move kind, no ramp, divider kick
	mpfh_word_type target_q, vop_q, vs_q, rate_q; // Latched move parameters
	mpfh_word_type div_num, div_den, div_quot; // Rate divider operands
	logic div_done; // Divider result valid
	logic [VEL_W-1:0] vel_fine_q, vel_next, vop_fine, vs_fine, floor_fine, rate_fine;
	logic [PH_W-1:0] phase_q, phase_sum; // Step phase
	mpfh_word_type pos_q, ramp_steps_q; // Position, steps spent accelerating
	logic [32:0] diff, remaining; // Signed distance, its magnitude
	logic at_target, braking; // Ramp decisions

	// ==========
	// Pin synchronisation and edges
	assign pins_raw = {electrical_origin_preset, stop_request, start_request, fast_homing_request};

	mpfh_sync #(.W(4)) u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	assign home_req_s = pins_s[0];
	assign start_s = pins_s[1];
	assign stop_s = pins_s[2];
	assign preset_s = pins_s[3];

	// Delayed copy for edge detection; reset low, so a pin held high across reset gives an edge after release
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pins_prev_q <= '0;
		end else begin
			pins_prev_q <= pins_s;
		end
	end

	// Only an edge counts, so the request must be released before the next one
	assign home_rise = home_req_s && !pins_prev_q[0]; // R15
	assign start_rise = start_s && !pins_prev_q[1];
	// Requests are honoured only while ready is shown
	assign accept_home = home_rise && ready && !preset_s && home_valid_q; // R6 R9 R13
	assign home_error = home_rise && ready && !preset_s && !home_valid_q; // R8

	// ==========
	// Register writes
	// Out-of-range values saturate to the nearest limit, except the unit code
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			unit_q <= UNIT_KHZ_PER_S; // R1
			sd_vs_q <= START_SPEED_RST;
			jog_vs_q <= START_SPEED_RST;
			zh_vs_q <= START_SPEED_RST;
			home_vs_q <= START_SPEED_RST;
			filter_q <= FILTER_RST;
			current_q <= CURRENT_RST;
			zh_vop_q <= ZH_SPEED_RST;
			zh_acc_q <= ACCEL_RST;
			home_pos_q <= '0;
			cmd_target_q <= '0;
			cmd_vop_q <= ZH_SPEED_RST;
		end else if (reg_write) begin
			case (reg_addr)
				// Code 3 is undefined and leaves the setting unchanged
				ADDR_ACCEL_UNIT: begin
					if (reg_wdata[1:0] != 2'h3) begin
						unit_q <= mpfh_unit_type'(reg_wdata[1:0]); // R1
					end
				end
				ADDR_SD_START_SPEED: sd_vs_q <= mpfh_clamp(reg_wdata, '0, SPEED_MAX); // R4
				ADDR_JOG_START_SPEED: jog_vs_q <= mpfh_clamp(reg_wdata, '0, SPEED_MAX); // R4
				ADDR_ZH_START_SPEED: zh_vs_q <= mpfh_clamp(reg_wdata, '0, SPEED_MAX); // R4
				ADDR_HOME_START_SPEED: home_vs_q <= mpfh_clamp(reg_wdata, 32'h1, SPEED_MAX); // R5
				ADDR_FILTER_TIME: filter_q <= mpfh_clamp(reg_wdata, FILTER_MIN, FILTER_MAX); // R10
				ADDR_OP_CURRENT: current_q <= mpfh_clamp(reg_wdata, '0, CURRENT_MAX); // R11
				ADDR_ZH_SPEED: zh_vop_q <= mpfh_clamp(reg_wdata, 32'h1, SPEED_MAX); // R11
				ADDR_ZH_ACCEL: zh_acc_q <= mpfh_clamp(reg_wdata, 32'h1, ACCEL_MAX); // R12
				ADDR_HOME_POSITION: home_pos_q <= reg_wdata;
				ADDR_CMD_TARGET: cmd_target_q <= reg_wdata;
				ADDR_CMD_SPEED: cmd_vop_q <= mpfh_clamp(reg_wdata, 32'h1, SPEED_MAX);
				default: ;
			endcase
		end
	end

	// Home validity: set by loading a home, lost on a control write with the forget-home bit set
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			home_valid_q <= 1'b0;
		end else if (reg_write && reg_addr == ADDR_HOME_POSITION) begin
			home_valid_q <= 1'b1;
		end else if (reg_write && reg_addr == ADDR_CONTROL && reg_wdata[CTL_FORGET_HOME]) begin
			home_valid_q <= 1'b0;
		end
	end

	// Sticky start error; a new error in the clearing cycle survives
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			start_err_q <= 1'b0;
		end else if (home_error) begin
			start_err_q <= 1'b1; // R8 R19
		end else if (reg_write && reg_addr == ADDR_CONTROL && reg_wdata[CTL_CLEAR_ERR]) begin
			start_err_q <= 1'b0;
		end
	end

	// ==========
	// Register reads: data valid in the cycle after the strobe only
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			case (reg_addr)
				ADDR_ACCEL_UNIT: reg_rdata <= {30'h0, unit_q};
				ADDR_SD_START_SPEED: reg_rdata <= sd_vs_q;
				ADDR_JOG_START_SPEED: reg_rdata <= jog_vs_q;
				ADDR_ZH_START_SPEED: reg_rdata <= zh_vs_q;
				ADDR_HOME_START_SPEED: reg_rdata <= home_vs_q;
				ADDR_FILTER_TIME: reg_rdata <= filter_q;
				ADDR_OP_CURRENT: reg_rdata <= current_q;
				ADDR_ZH_SPEED: reg_rdata <= zh_vop_q;
				ADDR_ZH_ACCEL: reg_rdata <= zh_acc_q;
				ADDR_HOME_POSITION: reg_rdata <= home_pos_q;
				ADDR_CMD_TARGET: reg_rdata <= cmd_target_q;
				ADDR_CMD_SPEED: reg_rdata <= cmd_vop_q;
				ADDR_STATUS: begin
					reg_rdata <= '0;
					reg_rdata[STS_START_ERR] <= start_err_q; // R19
					reg_rdata[STS_HOME_VALID] <= home_valid_q;
					reg_rdata[STS_MOVE] <= move;
					reg_rdata[STS_HOMING_DONE] <= homing_done;
					reg_rdata[STS_READY] <= ready;
				end
				ADDR_POSITION: reg_rdata <= pos_q;
				ADDR_RATE: reg_rdata <= rate_q;
				// Unmapped and write-only addresses read zero
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// ==========
	// Ramp rate: every unit is turned into Hz/s by one division
	always_comb begin
		div_num = zh_acc_q;
		div_den = 32'h1;
		case (unit_q)
			UNIT_KHZ_PER_S: begin
				div_num = zh_acc_q; // R1
				div_den = 32'h1;
			end
			// Time to span start..operating speed, weight 0.001 s
			UNIT_SECONDS: begin
				div_num = (vop_q - vs_q) * MS_PER_S; // R1
				div_den = zh_acc_q;
			end
			// Weight 0.001 ms per kHz inverts to 1e9/setting Hz/s
			UNIT_MS_PER_KHZ: begin
				div_num = RATE_NUM_INV; // R1
				div_den = zh_acc_q;
			end
			default: ;
		endcase
	end

	mpfh_div #(.W(32)) u_div (
		.sys_clk(sys_clk),
		.reset(reset),
		.start(div_start_q),
		.dividend(div_num),
		.divisor(div_den),
		.done(div_done),
		.quotient(div_quot)
	);

	// ==========
	// Motion sequencer
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			homing_q <= 1'b0;
			target_q <= '0;
			vop_q <= '0;
			vs_q <= '0;
			rect_q <= 1'b0;
			rate_q <= RATE_MIN;
			div_start_q <= 1'b0;
		end else begin
			div_start_q <= 1'b0;
			unique case (state_q)
				// Ready states: homing request wins over start
				ST_IDLE, ST_HOMED: begin
					if (accept_home) begin
						state_q <= ST_CALC; // R6 R14
						homing_q <= 1'b1;
						target_q <= home_pos_q;
						vop_q <= zh_vop_q;
						vs_q <= zh_vs_q;
						rect_q <= zh_vop_q < zh_vs_q; // R3
						div_start_q <= 1'b1;
					end else if (start_rise && !home_rise) begin
						state_q <= ST_CALC; // R17
						homing_q <= 1'b0;
						target_q <= cmd_target_q;
						vop_q <= cmd_vop_q;
						vs_q <= sd_vs_q;
						rect_q <= cmd_vop_q < sd_vs_q; // R3
						div_start_q <= 1'b1;
					end
				end
				// Waiting for the rate; stop abandons the move
				ST_CALC: begin
					if (stop_s) begin
						state_q <= ST_IDLE; // R7 R19
					end else if (div_done) begin
						rate_q <= mpfh_clamp(div_quot, RATE_MIN, RATE_MAX); // R2
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (stop_s) begin
						state_q <= ST_IDLE; // R7 R19
					end else if (at_target) begin
						state_q <= homing_q ? ST_HOMED : ST_IDLE; // R16
					end
				end
			endcase
		end
	end

	// ==========
	// Handshake outputs decoded from the sequencer
	assign ready = state_q == ST_IDLE || state_q == ST_HOMED; // R14 R16 R17
	assign in_position = ready; // R14 R16 R17
	assign move = state_q == ST_CALC || state_q == ST_RUN; // R14 R16 R17 R19
	assign homing_done = state_q == ST_HOMED; // R16 R17
	// Command readiness drops only for homing moves
	assign pulse_input_ready = !(move && homing_q); // R14 R16
	assign direct_command_ready = !(move && homing_q); // R14 R16
	assign operating_current = current_q[9:0];
	assign filter_time_ms = filter_q[7:0];

	// ==========
	// Trapezoid generator
	assign diff = {target_q[31], target_q} - {pos_q[31], pos_q};
	assign remaining = diff[32] ? 33'h0 - diff : diff;
	assign at_target = remaining == 33'h0;
	// Decelerate once the distance left equals the distance spent ramping up
	assign braking = remaining <= {1'b0, ramp_steps_q}; // R18
	assign vop_fine = VEL_W'(vop_q) * CLK_HZ_V;
	assign vs_fine = VEL_W'(vs_q) * CLK_HZ_V;
	// A zero starting speed would never finish; braking bottoms out at 1 Hz
	assign floor_fine = (vs_q == '0) ? CLK_HZ_V : vs_fine;
	assign rate_fine = VEL_W'(rate_q);
	assign phase_sum = phase_q + PH_W'(vel_fine_q);

	// Next speed: fixed when no ramp, else step by the rate toward the goal
	always_comb begin
		if (rect_q) begin
			vel_next = vop_fine; // R3
		end else if (braking) begin
			vel_next = (vel_fine_q > floor_fine + rate_fine) ? vel_fine_q - rate_fine : floor_fine; // R18
		end else begin
			vel_next = (vel_fine_q + rate_fine < vop_fine) ? vel_fine_q + rate_fine : vop_fine; // R18
		end
	end

	// Speed, phase and position; steps emitted while running only
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			vel_fine_q <= '0;
			phase_q <= '0;
			pos_q <= '0;
			ramp_steps_q <= '0;
			step_pulse <= 1'b0;
			step_direction <= 1'b0;
		end else begin
			step_pulse <= 1'b0;
			if (state_q == ST_CALC) begin
				// Begin at starting speed, or straight at operating speed
				vel_fine_q <= rect_q ? vop_fine : vs_fine; // R3 R18
				phase_q <= '0;
				ramp_steps_q <= '0;
				step_direction <= !diff[32];
			end else if (state_q == ST_RUN && !stop_s && !at_target) begin
				vel_fine_q <= vel_next;
				if (phase_sum >= STEP_THRESH) begin
					phase_q <= phase_sum - STEP_THRESH;
					step_pulse <= 1'b1;
					pos_q <= step_direction ? pos_q + 32'h1 : pos_q - 32'h1;
					if (!braking && vel_fine_q < vop_fine) begin
						ramp_steps_q <= ramp_steps_q + 32'h1; // R18
					end
				end else begin
					phase_q <= phase_sum;
				end
			end else begin
				// Stopped: speed drops to zero at once
				vel_fine_q <= '0; // R7
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/mpfh_top_assertions.sv
// Purpose: Port-level checks of the fast homing handshake and settings outputs
// Assumes: Bound to mpfh_top; one clock domain
// Notes: Pins pass two sync flops, so pin windows are held several cycles
`default_nettype none
module mpfh_top_assertions (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic start_request,
	input wire logic stop_request,
	input wire logic electrical_origin_preset,
	input wire logic ready,
	input wire logic in_position,
	input wire logic pulse_input_ready,
	input wire logic direct_command_ready,
	input wire logic move,
	input wire logic homing_done,
	input wire logic [9:0] operating_current,
	input wire logic [7:0] filter_time_ms
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	// ==========
	// Pin windows long enough to cross the synchroniser
	sequence s_stop_held;
		stop_request[*3];
	endsequence
	sequence s_preset_held;
		(electrical_origin_preset && !start_request)[*4];
	endsequence
	// ==========
	// Handshake and settings output properties
	property p_ready_pair;
		ready == in_position;
	endproperty
	property p_stop;
		s_stop_held |-> ##[0:3] !move;
	endproperty
	property p_preset;
		s_preset_held ##0 !move |=> !move;
	endproperty
	property p_homing_busy;
		!pulse_input_ready |-> move && !ready && !direct_command_ready;
	endproperty
	property p_start_drop;
		$fell(homing_done) |-> move && !ready;
	endproperty
	property p_arrival;
		$rose(homing_done) |-> $past(move) && !move && ready && pulse_input_ready && direct_command_ready;
	endproperty
	property p_filter;
		filter_time_ms >= 8'h01 && filter_time_ms <= 8'hC8;
	endproperty
	property p_current;
		operating_current <= 10'h3E8;
	endproperty
	a_ready_pair: assert property (p_ready_pair) else $error("ready pair");
	a_stop: assert property (p_stop) else $error("stop");
	a_preset: assert property (p_preset) else $error("preset");
	a_homing_busy: assert property (p_homing_busy) else $error("busy");
	a_start_drop: assert property (p_start_drop) else $error("start drop");
	a_arrival: assert property (p_arrival) else $error("arrival");
	a_filter: assert property (p_filter) else $error("filter");
	a_current: assert property (p_current) else $error("current");
endmodule
bind mpfh_top mpfh_top_assertions mpfh_top_assertions_inst (.*);
`default_nettype wire

// ===== tb/mpfh_host.sv
// Purpose: Host controller model driving the homing and start pins
// Assumes: do_home and do_start are one-cycle commands from the bench
// Notes: A refused request never drops ready, so release after a timeout
`default_nettype none
module mpfh_host (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic ready,
	input wire logic do_home,
	input wire logic do_start,
	output logic fast_homing_request,
	output logic start_request
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] hold_q; // Cycles the request has been held
	logic [2:0] start_q; // Remaining start pulse cycles
	// Homing request: raise only while ready, drop once ready falls
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			fast_homing_request <= 1'b0;
		end else if (do_home && ready) begin
			fast_homing_request <= 1'b1;
		end else if (fast_homing_request && (!ready || hold_q == 5'h1F)) begin
			fast_homing_request <= 1'b0;
		end
	end
	// Hold timer
	always_ff @(posedge sys_clk) begin
		hold_q <= (reset || !fast_homing_request) ? 5'h00 : hold_q + 5'h01;
	end
	// Start pin held four cycles so the synchroniser sees it
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			start_q <= 3'h0;
		end else if (do_start) begin
			start_q <= 3'h4;
		end else if (start_q != 3'h0) begin
			start_q <= start_q - 3'h1;
		end
	end
	assign start_request = (start_q != 3'h0);
endmodule
`default_nettype wire

// ===== tb/mpfh_top_tb.sv
// Purpose: Self-checking bench of the motion profile and fast homing block
// Assumes: Host model drives homing and start pins
// Notes: Start speeds set above operating speed keep moves short
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
	$display("unexpected %s exp %0h got %0h", nm, exp, got); end end
module mpfh_top_tb import mpfh_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, reset, reg_write, reg_read, stop_request, electrical_origin_preset, do_home, do_start;
	mpfh_addr_type reg_addr;
	mpfh_word_type reg_wdata, reg_rdata, v;
	logic fast_homing_request, start_request, ready, in_position, pulse_input_ready, direct_command_ready;
	logic move, homing_done, step_pulse, step_direction;
	logic [9:0] operating_current;
	logic [7:0] filter_time_ms;
	int fails, total_checks, cycles, steps, gap, gmin, gmax;
	mpfh_addr_type ra[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
	mpfh_word_type rv[9] = '{32'h0, 32'h1F4, 32'h1F4, 32'h1F4, 32'h1F4, 32'h1, 32'h3E8, 32'h1388, 32'hF4240};
	mpfh_addr_type sa[5] = '{8'h14, 8'h18, 8'h10, 8'h04, 8'h20};
	mpfh_word_type lo[5] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h1};
	mpfh_word_type hi[5] = '{32'hC8, 32'h3E8, 32'h3D0900, 32'h3D0900, 32'h3B9ACA00};
	mpfh_top mpfh_top_inst (.sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.fast_homing_request, .start_request, .stop_request, .electrical_origin_preset, .ready, .in_position,
		.pulse_input_ready, .direct_command_ready, .move, .homing_done, .step_pulse, .step_direction,
		.operating_current, .filter_time_ms);
	mpfh_host mpfh_host_inst (.sys_clk, .reset, .ready, .do_home, .do_start, .fast_homing_request, .start_request);
	// ==========
	// Clock, timeout and step gap monitor
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		gap++;
		if (step_pulse === 1'b1) begin
			if (steps > 0 && gap < gmin) gmin = gap;
			if (steps > 0 && gap > gmax) gmax = gap;
			steps++;
			gap = 0;
		end
		if (cycles == 20000) begin
			fails++;
			finish_test();
		end
	end
	// Expected value of a saturating setting
	function automatic mpfh_word_type sat(mpfh_word_type x, mpfh_word_type l, mpfh_word_type h);
		return (x < l) ? l : (x > h) ? h : x;
	endfunction
	// ==========
	// Register bus and pin tasks
	task automatic wr(mpfh_addr_type a, mpfh_word_type d);
		@(posedge sys_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(mpfh_addr_type a, mpfh_word_type e, string nm);
		@(posedge sys_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1;
		`CHK(nm, e, reg_rdata)
	endtask
	task automatic cmd(logic home);
		@(posedge sys_clk);
		do_home <= home;
		do_start <= !home;
		@(posedge sys_clk);
		do_home <= 1'b0;
		do_start <= 1'b0;
	endtask
	// Bounded wait for move or homing_done to reach a level
	task automatic wait_sig(string nm, logic lv, int n);
		int i = 0;
		while (((nm == "move") ? move : homing_done) !== lv && i < n) begin
			@(posedge sys_clk);
			#1;
			i++;
		end
		`CHK(nm, lv, ((nm == "move") ? move : homing_done))
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ==========
	// Main sequence
	initial begin
		{sys_clk, reg_write, reg_read, stop_request, electrical_origin_preset, do_home, do_start} = '0;
		reset = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		{fails, total_checks, cycles, steps, gap} = '0;
		void'($urandom(32'hF031E3BE));
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		foreach (ra[i]) rd(ra[i], rv[i], "reset value");
		rd(8'h40, 32'h0, "unmapped");
		for (int u = 0; u < 4; u++) begin
			wr(ADDR_ACCEL_UNIT, u);
			rd(ADDR_ACCEL_UNIT, (u < 3) ? u : 2, "unit");
		end
		// Corner values first, then random ones spread over all magnitudes
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFFFFFF : $urandom >> ($urandom % 32);
			foreach (sa[i]) begin
				wr(sa[i], v);
				rd(sa[i], sat(v, lo[i], hi[i]), "saturated");
			end
		end
		`CHK("filter pin", 8'(sat(v, lo[0], hi[0])), filter_time_ms)
		`CHK("current pin", 10'(sat(v, lo[1], hi[1])), operating_current)
		// Homing with no home set is refused and flagged
		wr(ADDR_ACCEL_UNIT, 32'h0);
		cmd(1'b1);
		repeat (40) @(posedge sys_clk);
		`CHK("move refused", 1'b0, move)
		rd(ADDR_STATUS, 32'h11, "status flagged");
		rd(ADDR_STATUS, 32'h11, "status sticky");
		wr(ADDR_CONTROL, 32'h2);
		rd(ADDR_STATUS, 32'h10, "status cleared");
		// Preset blocks homing
		wr(ADDR_HOME_POSITION, 32'h0);
		electrical_origin_preset <= 1'b1;
		cmd(1'b1);
		repeat (40) @(posedge sys_clk);
		`CHK("move preset", 1'b0, move)
		rd(ADDR_STATUS, 32'h12, "status preset");
		electrical_origin_preset <= 1'b0;
		// Homing already at home completes
		wr(ADDR_ZH_START_SPEED, 32'h3D0900);
		wr(ADDR_ZH_SPEED, 32'hF4240);
		cmd(1'b1);
		wait_sig("move", 1'b1, 10);
		`CHK("ready busy", 1'b0, ready)
		wait_sig("homing_done", 1'b1, 100);
		`CHK("ready home", 1'b1, ready)
		rd(ADDR_STATUS, 32'h1A, "status homed");
		// Commanded move below starting speed runs without ramp
		wr(ADDR_SD_START_SPEED, 32'h3D0900);
		wr(ADDR_CMD_SPEED, 32'hF4240);
		wr(ADDR_CMD_TARGET, 32'd40);
		{steps, gmax} = '0;
		gmin = 1000;
		cmd(1'b0);
		wait_sig("move", 1'b1, 10);
		`CHK("done after start", 1'b0, homing_done)
		wait_sig("move", 1'b0, 2000);
		`CHK("step count", 40, steps)
		`CHK("gap min", 25, gmin)
		`CHK("gap max", 25, gmax)
		`CHK("direction", 1'b1, step_direction)
		rd(ADDR_POSITION, 32'd40, "position");
		// Homing stopped midway
		wr(ADDR_ACCEL_UNIT, 32'h2);
		wr(ADDR_ZH_ACCEL, 32'h1);
		steps = 0;
		cmd(1'b1);
		wait_sig("move", 1'b1, 10);
		for (int i = 0; i < 2000 && steps < 10; i++) @(posedge sys_clk);
		stop_request <= 1'b1;
		wait_sig("move", 1'b0, 6);
		`CHK("done after stop", 1'b0, homing_done)
		stop_request <= 1'b0;
		rd(ADDR_POSITION, 32'd40 - steps, "stopped position");
		rd(ADDR_RATE, 32'h3B9ACA00, "rate");
		rd(ADDR_STATUS, 32'h12, "status stopped");
		finish_test();
	end
endmodule
`default_nettype wire
